//--- analog_input_acq_sequencer.sv
// analog input acquisition sequencer with apb registers and result fifo
//
// Contract
// R1: soft strobe access starts one conversion
// R2: external low pulse starts a conversion
// R3: conversion end pushes result into fifo
// R4: not-empty flag tracks fifo; data read pops
// R5: empty fifo read returns junk, no change
// R6: host checks status before reading fifo
// R7: not-empty about 10 us after start
// R8: full fifo drops result, sets overflow
// R9: start during conversion sets sticky overrun
// R10: clear strobe resets overflow and overrun
// R11: counters reload, stay armed for retrigger
// R12: start strobe or trigger fall starts acquisition
// R13: pretrigger counts only after second trigger
// R14: config memory entries drive successive conversions
// R15: continuous scan wraps with no delay
// R16: scanning needs scan and acquisition enables
// R17: scan interval counter starts each pass
// R18: interval scan waits for scan terminal count
// R19: conversions in a pass spaced by interval
// R20: host sets scan interval long enough
// R21: last marker ends pass, wrap to first
// R22: sample counter stops conversions at count
// R23: clear also empties fifo, clears complete
// R24: status reads clear nothing
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module analog_input_acq_sequencer
  import acq_seq_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  ext_convert_n,
  input  wire logic                  ext_trigger_n,
  input  wire logic [RES_WIDTH-1:0]  adc_result,
  output logic      [CFG_WIDTH-1:0]  adc_config,
  output logic                       adc_busy,
  output logic                       result_fifo_not_empty
);

  typedef enum logic [1:0] {ACQ_IDLE, ACQ_PRE, ACQ_RUN, ACQ_HOLD} acq_state_e;

  // bus decode
  logic access_w;                               // access phase of any transfer
  logic wr_w;                                   // write access
  logic rd_w;                                   // read access
  assign access_w = psel && penable;
  assign wr_w     = access_w && pwrite;
  assign rd_w     = access_w && !pwrite;
  assign pready   = 1'b1;                       // zero wait state slave

  // address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  logic soft_convert_pulse;                     // any access to the soft convert slot
  logic acq_start_strobe;                       // any access to the start slot
  logic acq_clear_strobe;                       // any access to the clear slot
  logic fifo_read_w;                            // read of the fifo data slot
  assign soft_convert_pulse = access_w && hit(paddr, ADDR_SOFT_CONV);   // R1
  assign acq_start_strobe   = access_w && hit(paddr, ADDR_ACQ_START);
  assign acq_clear_strobe   = access_w && hit(paddr, ADDR_ACQ_CLEAR);
  assign fifo_read_w        = rd_w && hit(paddr, ADDR_FIFO_DATA);

  // configuration registers
  logic [CTL_WIDTH-1:0]    ctrl_q;              // control bits
  logic [15:0]             sample_ivl_q;        // cycles between conversions
  logic [16:0]             sample_cnt_q;        // programmed sample count
  logic [23:0]             scan_ivl_q;          // cycles per scan pass
  logic [CFG_DEPTH_LG-1:0] cfg_wptr_q;          // config memory write pointer
  logic [CFG_WIDTH-1:0]    cfg_mem [2**CFG_DEPTH_LG]; // channel configuration memory
  logic acquisition_enable_bit;
  logic scan_enable_bit;
  logic scan_interval_enable_bit;
  assign acquisition_enable_bit   = ctrl_q[CTL_ACQ_EN];
  assign scan_enable_bit          = ctrl_q[CTL_SCAN_EN];
  assign scan_interval_enable_bit = ctrl_q[CTL_SCAN_IVL];

  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q       <= '0;
      sample_ivl_q <= 16'h0002;
      sample_cnt_q <= 17'h00002;
      scan_ivl_q   <= 24'h000100;
      cfg_wptr_q   <= '0;
    end else if (wr_w) begin
      if (hit(paddr, ADDR_CONTROL)) begin
        ctrl_q <= pwdata[CTL_WIDTH-1:0];
      end else if (hit(paddr, ADDR_SAMPLE_IVL)) begin
        sample_ivl_q <= pwdata[15:0];
      end else if (hit(paddr, ADDR_SAMPLE_CNT)) begin
        sample_cnt_q <= pwdata[16:0];
      end else if (hit(paddr, ADDR_SCAN_IVL)) begin
        scan_ivl_q <= pwdata[23:0];
      end else if (hit(paddr, ADDR_CFG_INDEX)) begin
        cfg_wptr_q <= pwdata[CFG_DEPTH_LG-1:0];
      end else if (hit(paddr, ADDR_CFG_DATA)) begin
        cfg_wptr_q <= cfg_wptr_q + 1'b1;        // auto increment per entry
      end
    end
  end

  // config memory storage, no reset
  always_ff @(posedge pclk) begin
    if (wr_w && hit(paddr, ADDR_CFG_DATA)) begin
      cfg_mem[cfg_wptr_q] <= pwdata[CFG_WIDTH-1:0];
    end
  end

  // external input edge detect
  logic conv_n_q;                               // last external convert level
  logic trig_n_q;                               // last external trigger level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_n_q <= 1'b1;
      trig_n_q <= 1'b1;
    end else begin
      conv_n_q <= ext_convert_n;
      trig_n_q <= ext_trigger_n;
    end
  end
  logic ext_conv_fall;
  logic trigger_w;
  assign ext_conv_fall = conv_n_q && !ext_convert_n;                   // R2
  assign trigger_w     = acq_start_strobe || (trig_n_q && !ext_trigger_n); // R12

  // acquisition sequencer
  acq_state_e              acq_q;               // acquisition state
  logic [15:0]             ivl_cnt_q;           // sample interval timer
  logic [16:0]             left_q;              // samples remaining
  logic [23:0]             scan_cnt_q;          // scan interval timer
  logic [CFG_DEPTH_LG-1:0] entry_q;             // current config entry
  logic                    complete_q;          // acquisition complete flag
  logic                    seq_conv_w;          // sequencer conversion start
  logic                    tick_w;              // timing event in run state
  logic                    pass_end_w;          // current entry is last of pass
  logic                    scanning_w;          // scan mode active
  assign scanning_w = scan_enable_bit && acquisition_enable_bit;       // R16
  assign pass_end_w = cfg_mem[entry_q][CFG_LAST_BIT];                  // R21
  assign tick_w     = ctrl_q[CTL_EXT_TIMED] ? ext_conv_fall : (ivl_cnt_q == 16'h0001);
  assign seq_conv_w = (acq_q == ACQ_RUN) && tick_w && (left_q != '0);  // R22
  assign adc_config = cfg_mem[scanning_w ? entry_q : '0];              // R14

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_q      <= ACQ_IDLE;
      ivl_cnt_q  <= '0;
      left_q     <= '0;
      scan_cnt_q <= '0;
      entry_q    <= '0;
      complete_q <= 1'b0;
    end else if (acq_clear_strobe) begin
      acq_q      <= ACQ_IDLE;                   // R23
      complete_q <= 1'b0;                       // R23
      entry_q    <= '0;
    end else begin
      // free scan interval timer countdown
      if (scan_cnt_q != '0) begin
        scan_cnt_q <= scan_cnt_q - 1'b1;
      end
      case (acq_q)
        ACQ_IDLE: begin
          if (acquisition_enable_bit && trigger_w) begin
            ivl_cnt_q <= sample_ivl_q;
            left_q    <= sample_cnt_q;
            entry_q   <= '0;
            complete_q <= 1'b0;
            if (ctrl_q[CTL_PRETRIG]) begin
              acq_q <= ACQ_PRE;                 // R13
            end else begin
              acq_q      <= ACQ_RUN;            // R13
              scan_cnt_q <= scan_ivl_q;         // R17
            end
          end
        end
        ACQ_PRE: begin
          if (trigger_w) begin
            acq_q      <= ACQ_RUN;              // R13
            scan_cnt_q <= scan_ivl_q;           // R17
          end
        end
        ACQ_RUN: begin
          // sample interval timer reloads every period
          ivl_cnt_q <= (ivl_cnt_q <= 16'h0001) ? sample_ivl_q : ivl_cnt_q - 1'b1; // R19
          if (seq_conv_w) begin
            left_q <= left_q - 1'b1;
            if (scanning_w) begin
              if (pass_end_w) begin
                entry_q <= '0;                  // R21
                if (scan_interval_enable_bit) begin
                  acq_q <= ACQ_HOLD;            // R18
                end else begin
                  scan_cnt_q <= scan_ivl_q;     // R15
                end
              end else begin
                entry_q <= entry_q + 1'b1;      // R14
              end
            end
            if (left_q == 17'h00001) begin
              acq_q      <= ACQ_IDLE;           // R11
              complete_q <= 1'b1;
              entry_q    <= '0;
            end
          end
        end
        ACQ_HOLD: begin
          if (scan_cnt_q <= 24'h000001) begin
            acq_q      <= ACQ_RUN;              // R18
            scan_cnt_q <= scan_ivl_q;           // R17
            ivl_cnt_q  <= sample_ivl_q;         // R19
          end
        end
        default: acq_q <= ACQ_IDLE;
      endcase
    end
  end

  // converter model: busy for the conversion time, then result ready
  logic start_w;                                // any conversion request
  logic [11:0] conv_cnt_q;                      // conversion time countdown
  logic busy_q;                                 // conversion in progress
  logic done_w;                                 // conversion cycle ends
  logic overrun_q;                              // sticky overrun flag
  assign start_w = soft_convert_pulse
                 || (ext_conv_fall && (acq_q == ACQ_IDLE))              // R2
                 || seq_conv_w;
  assign done_w  = busy_q && (conv_cnt_q == 12'h001);
  assign adc_busy = busy_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q     <= 1'b0;
      conv_cnt_q <= '0;
    end else if (start_w && !busy_q) begin
      busy_q     <= 1'b1;                       // R1
      conv_cnt_q <= 12'(CONV_CYCLES);           // R7
    end else if (busy_q) begin
      conv_cnt_q <= conv_cnt_q - 1'b1;
      if (conv_cnt_q == 12'h001) begin
        busy_q <= 1'b0;
      end
    end
  end

  // sticky overrun, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_q <= 1'b0;
    end else if (start_w && busy_q && !done_w) begin
      overrun_q <= 1'b1;                        // R9
    end else if (acq_clear_strobe) begin
      overrun_q <= 1'b0;                        // R10
    end
  end

  // result fifo
  logic [RES_WIDTH-1:0] fifo_mem [FIFO_DEPTH];  // result storage
  logic [FIFO_AW-1:0]   wptr_q;                 // write pointer
  logic [FIFO_AW-1:0]   rptr_q;                 // read pointer
  logic [FIFO_AW:0]     count_q;                // results held
  logic                 overflow_q;             // sticky overflow flag
  logic                 full_w;
  logic                 push_w;
  logic                 pop_w;
  assign full_w = (count_q == (FIFO_AW+1)'(FIFO_DEPTH));
  assign push_w = done_w && !full_w && !acq_clear_strobe;              // R3
  assign pop_w  = fifo_read_w && (count_q != '0) && !acq_clear_strobe; // R5
  assign result_fifo_not_empty = (count_q != '0);                      // R4

  always_ff @(posedge pclk) begin
    if (push_w) begin
      fifo_mem[wptr_q] <= adc_result;
    end
  end

  // fifo pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q  <= '0;
      rptr_q  <= '0;
      count_q <= '0;
    end else if (acq_clear_strobe) begin
      wptr_q  <= '0;                            // R23
      rptr_q  <= '0;
      count_q <= '0;
    end else begin
      if (push_w) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (pop_w) begin
        rptr_q <= rptr_q + 1'b1;                // R4
      end
      count_q <= count_q + (FIFO_AW+1)'(push_w) - (FIFO_AW+1)'(pop_w);
    end
  end

  // sticky overflow, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_q <= 1'b0;
    end else if (done_w && full_w) begin
      overflow_q <= 1'b1;                       // R8
    end else if (acq_clear_strobe) begin
      overflow_q <= 1'b0;                       // R10
    end
  end

  // read mux, registered on the setup cycle so data is ready in access
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = RESET_VALUE;
    if (hit(paddr, ADDR_STATUS)) begin
      rdata_d[ST_NOT_EMPTY] = result_fifo_not_empty; // R24
      rdata_d[ST_OVERFLOW]  = overflow_q;
      rdata_d[ST_OVERRUN]   = overrun_q;
      rdata_d[ST_COMPLETE]  = complete_q;
      rdata_d[ST_BUSY]      = busy_q;
      rdata_d[ST_ARMED]     = (acq_q != ACQ_IDLE);
    end else if (hit(paddr, ADDR_FIFO_DATA)) begin
      rdata_d[RES_WIDTH-1:0] = fifo_mem[rptr_q];     // R5
    end else if (hit(paddr, ADDR_CONTROL)) begin
      rdata_d[CTL_WIDTH-1:0] = ctrl_q;
    end else if (hit(paddr, ADDR_SAMPLE_IVL)) begin
      rdata_d[15:0] = sample_ivl_q;
    end else if (hit(paddr, ADDR_SAMPLE_CNT)) begin
      rdata_d[16:0] = left_q;
    end else if (hit(paddr, ADDR_SCAN_IVL)) begin
      rdata_d[23:0] = scan_ivl_q;
    end else if (hit(paddr, ADDR_CFG_INDEX)) begin
      rdata_d[CFG_DEPTH_LG-1:0] = cfg_wptr_q;
    end
  end

  // read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RESET_VALUE;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_d;
    end
  end

  // error for unmapped offsets
  assign pslverr = access_w && (paddr > ADDR_CFG_DATA || paddr[1:0] != 2'b00);

endmodule

//--- acq_seq_pkg.sv
// package of constants for the analog input acquisition sequencer
package acq_seq_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_SOFT_CONV   = 8'h00; // write or read: single conversion
  localparam logic [7:0] ADDR_ACQ_START   = 8'h04; // write or read: start acquisition
  localparam logic [7:0] ADDR_ACQ_CLEAR   = 8'h08; // write or read: clear errors and fifo
  localparam logic [7:0] ADDR_CONTROL     = 8'h0c; // control bits
  localparam logic [7:0] ADDR_STATUS      = 8'h10; // status flags
  localparam logic [7:0] ADDR_FIFO_DATA   = 8'h14; // result fifo pop
  localparam logic [7:0] ADDR_SAMPLE_IVL  = 8'h18; // sample interval in cycles
  localparam logic [7:0] ADDR_SAMPLE_CNT  = 8'h1c; // sample count
  localparam logic [7:0] ADDR_SCAN_IVL    = 8'h20; // scan interval in cycles
  localparam logic [7:0] ADDR_CFG_INDEX   = 8'h24; // config memory write pointer
  localparam logic [7:0] ADDR_CFG_DATA    = 8'h28; // config memory entry write
  // control field positions
  localparam int CTL_ACQ_EN    = 0;
  localparam int CTL_SCAN_EN   = 1;
  localparam int CTL_SCAN_IVL  = 2;
  localparam int CTL_PRETRIG   = 3;
  localparam int CTL_EXT_TIMED = 4;
  localparam int CTL_WIDTH     = 5;
  // status field positions
  localparam int ST_NOT_EMPTY  = 0;
  localparam int ST_OVERFLOW   = 1;
  localparam int ST_OVERRUN    = 2;
  localparam int ST_COMPLETE   = 3;
  localparam int ST_BUSY       = 4;
  localparam int ST_ARMED      = 5;
  // config entry layout: last marker bit, rest is channel/gain/mode/range
  localparam int CFG_WIDTH     = 16;
  localparam int CFG_LAST_BIT  = 15;
  localparam int CFG_DEPTH_LG  = 4;
  // fifo
  localparam int FIFO_DEPTH    = 512;
  localparam int FIFO_AW       = 9;
  localparam int RES_WIDTH     = 16;
  // conversion timing
  localparam int CLK_MHZ       = 250;
  localparam int CONV_TIME_US  = 10;
  localparam int CONV_CYCLES   = CONV_TIME_US * CLK_MHZ;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
endpackage

//--- acq_seq_props.sv
// port checker for the acquisition sequencer
`timescale 1ns/1ps
module acq_seq_props
  import acq_seq_pkg::*;
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 ext_convert_n,
  input wire logic                 ext_trigger_n,
  input wire logic [RES_WIDTH-1:0] adc_result,
  input wire logic [CFG_WIDTH-1:0] adc_config,
  input wire logic                 adc_busy,
  input wire logic                 result_fifo_not_empty
);
  logic [11:0] busy_cnt_q; // cycles the running conversion has lasted
  logic [2:0]  idle_q;     // cycles since busy dropped, saturating
  logic        acc;        // apb access phase
  assign acc = psel && penable;
  // track conversion length and quiet time after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt_q <= 12'h000;
      idle_q     <= 3'h0;
    end else begin
      busy_cnt_q <= adc_busy ? busy_cnt_q + 12'h001 : 12'h000;
      idle_q     <= adc_busy ? 3'h0 : idle_q + {2'h0, idle_q != 3'h7};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  soft_conv_a: assert property (
    acc && paddr == ADDR_SOFT_CONV && !adc_busy |-> ##[1:2] adc_busy)
    else $error("soft strobe did not start a conversion");
  ext_conv_a: assert property (
    $fell(ext_convert_n) && idle_q == 3'h7 |-> ##[1:4] adc_busy)
    else $error("external low pulse did not start a conversion");
  conv_len_a: assert property (
    $fell(adc_busy) |-> busy_cnt_q inside {[CONV_CYCLES-2:CONV_CYCLES]})
    else $error("conversion length wrong");
  overrun_hold_a: assert property (
    acc && paddr == ADDR_SOFT_CONV && adc_busy && busy_cnt_q < 12'h9c0
    |=> adc_busy && busy_cnt_q == $past(busy_cnt_q) + 12'h001)
    else $error("start during conversion restarted it");
  push_flag_a: assert property (
    $fell(adc_busy) |-> ##[0:2] result_fifo_not_empty)
    else $error("finished conversion not pushed");
  empty_read_a: assert property (
    acc && !pwrite && paddr == ADDR_FIFO_DATA && !result_fifo_not_empty && idle_q == 3'h7
    |=> !result_fifo_not_empty)
    else $error("empty fifo read changed the flag");
  status_keep_a: assert property (
    acc && !pwrite && paddr == ADDR_STATUS && idle_q == 3'h7 |=> $stable(result_fifo_not_empty))
    else $error("status read changed the flag");
  clear_empties_a: assert property (
    acc && paddr == ADDR_ACQ_CLEAR && idle_q == 3'h7 |=> !result_fifo_not_empty)
    else $error("clear strobe left data in fifo");
endmodule

//--- adc_model.sv
// behavioural converter front end facing the sequencer
`timescale 1ns/1ps
module adc_model
  import acq_seq_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 adc_busy,
  input  wire logic [CFG_WIDTH-1:0] adc_config,
  output logic      [RES_WIDTH-1:0] adc_result
);
  logic                 busy_q;     // busy one cycle ago
  logic [CFG_WIDTH-1:0] cfg_seen_q; // config standing at the start edge
  initial adc_result = 16'h0000;
  initial busy_q = 1'b0;
  // echo the config taken at conversion start; toggle junk while idle
  // the sequencer steps its entry on the start edge, so keep the idle view
  always @(posedge pclk) begin
    busy_q <= adc_busy;
    if (!adc_busy) begin
      cfg_seen_q <= adc_config;
    end
    if (adc_busy && !busy_q) begin
      adc_result <= cfg_seen_q;
    end else if (!adc_busy) begin
      adc_result <= ~adc_result;
    end
  end
endmodule

//--- tb_top.sv
// self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
module tb_top;
  import acq_seq_pkg::*;
  localparam logic [31:0] acq_bit = 32'h1 << CTL_ACQ_EN;   // acquisition enable
  localparam logic [31:0] scn_bit = 32'h1 << CTL_SCAN_EN;  // scan enable
  localparam logic [31:0] ivl_bit = 32'h1 << CTL_SCAN_IVL; // scan interval enable
  localparam logic [31:0] pre_bit = 32'h1 << CTL_PRETRIG;  // pretrigger mode
  logic        pclk, presetn, psel, penable, pwrite, ext_convert_n, ext_trigger_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, adc_busy, result_fifo_not_empty, slv;
  logic [15:0] adc_result, adc_config;
  logic [15:0] cfg [3];  // shadow of the scan list
  integer      n_errors, checked, seed, cyc, t_last;
  integer      gaps [8]; // arrival spacing of collected results
  analog_input_acq_sequencer analog_input_acq_sequencer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_convert_n(ext_convert_n), .ext_trigger_n(ext_trigger_n), .adc_result(adc_result),
    .adc_config(adc_config), .adc_busy(adc_busy),
    .result_fifo_not_empty(result_fifo_not_empty));
  adc_model adc_model_inst (
    .pclk(pclk), .adc_busy(adc_busy), .adc_config(adc_config), .adc_result(adc_result));
  // clock and cycle count
  always #2 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  // one apb transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // compare and count
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // expected result: scan list order or entry zero
  function automatic logic [31:0] exp_res(input int i, input logic scan);
    return {16'h0000, cfg[scan ? i % 3 : 0]};
  endfunction
  function automatic logic [31:0] gap_ok(input integer g, input integer e);
    return {31'h0, g >= e - 4 && g <= e + 4};
  endfunction
  // bounded wait for the not-empty flag
  task automatic wait_ne(input integer lim);
    integer k;
    k = 0;
    @(posedge pclk); // let a pop from the last access settle first
    while (result_fifo_not_empty !== 1'b1 && k < lim) begin
      @(posedge pclk);
      k++;
    end
    cmp("not_empty", 32'h1, {31'h0, result_fifo_not_empty});
  endtask
  // pick up n results as they arrive, noting spacing
  task automatic collect(input int n, input logic scan);
    for (int i = 0; i < n; i++) begin
      wait_ne(12000);
      gaps[i] = cyc - t_last;
      t_last  = cyc;
      apb(1'b0, ADDR_FIFO_DATA, 32'h0);
      cmp("fifo", exp_res(i, scan), rd);
    end
  endtask
  task automatic status(input logic [31:0] exp);
    apb(1'b0, ADDR_STATUS, 32'h0);
    cmp("status", exp, rd & 32'h1f);
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (95000) @(posedge pclk);
    n_errors++;
    give_verdict;
  end
  // main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite} = 5'h00;
    {ext_convert_n, ext_trigger_n} = 2'h3;
    paddr = 8'h00;
    pwdata = 32'h0;
    {n_errors, checked, cyc, t_last} = '0;
    seed = 73;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, ADDR_CFG_INDEX, 32'h0);
    for (int i = 0; i < 3; i++) begin
      cfg[i] = 16'($random(seed));
      cfg[i][CFG_LAST_BIT] = (i == 2); // marker on the last entry
      apb(1'b1, ADDR_CFG_DATA, {16'h0, cfg[i]});
    end
    apb(1'b0, 8'h40, 32'h0);
    cmp("slverr", 32'h1, {31'h0, slv});
    // single soft conversion, then empty read
    apb(1'b1, ADDR_SOFT_CONV, $random(seed));
    t_last = cyc;
    wait_ne(3000);
    cmp("arrival", 32'h1, gap_ok(cyc - t_last, CONV_CYCLES + 2));
    status(32'h1 << ST_NOT_EMPTY);
    collect(1, 1'b0);
    apb(1'b0, ADDR_FIFO_DATA, 32'h0);
    status(32'h0);
    // back-to-back starts give overrun, clear removes it
    apb(1'b1, ADDR_SOFT_CONV, 32'h0);
    apb(1'b0, ADDR_SOFT_CONV, 32'h0);
    repeat (2600) @(posedge pclk);
    status((32'h1 << ST_NOT_EMPTY) | (32'h1 << ST_OVERRUN));
    status((32'h1 << ST_NOT_EMPTY) | (32'h1 << ST_OVERRUN));
    apb(1'b1, ADDR_ACQ_CLEAR, $random(seed));
    status(32'h0);
    // external convert pulse
    @(posedge pclk);
    ext_convert_n <= 1'b0;
    t_last = cyc;
    repeat (3) @(posedge pclk);
    ext_convert_n <= 1'b1;
    wait_ne(3000);
    cmp("arrival", 32'h1, gap_ok(cyc - t_last, CONV_CYCLES + 4));
    collect(1, 1'b0);
    // continuous scan started by trigger fall
    apb(1'b1, ADDR_SAMPLE_IVL, 32'ha28);
    apb(1'b1, ADDR_SAMPLE_CNT, 32'h5);
    apb(1'b1, ADDR_CONTROL, acq_bit | scn_bit);
    @(posedge pclk);
    ext_trigger_n <= 1'b0;
    repeat (3) @(posedge pclk);
    ext_trigger_n <= 1'b1;
    collect(5, 1'b1);
    cmp("gap", 32'h1, gap_ok(gaps[3], 32'ha28));
    repeat (3000) @(posedge pclk);
    status(32'h1 << ST_COMPLETE);
    // rearmed: strobe restarts with scanning off
    apb(1'b1, ADDR_CONTROL, acq_bit);
    apb(1'b0, ADDR_ACQ_START, 32'h0);
    collect(5, 1'b0);
    // pretrigger needs a second trigger
    apb(1'b1, ADDR_ACQ_CLEAR, 32'h0);
    apb(1'b1, ADDR_SAMPLE_CNT, 32'h2);
    apb(1'b1, ADDR_CONTROL, acq_bit | pre_bit);
    apb(1'b1, ADDR_ACQ_START, 32'h0);
    repeat (6000) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    cmp("complete", 32'h0, rd & (32'h1 << ST_COMPLETE));
    apb(1'b1, ADDR_ACQ_START, 32'h0);
    repeat (8000) @(posedge pclk); // let the last conversion finish before clear
    apb(1'b0, ADDR_STATUS, 32'h0);
    cmp("complete", 32'h1 << ST_COMPLETE, rd & (32'h1 << ST_COMPLETE));
    apb(1'b1, ADDR_ACQ_CLEAR, 32'h0);
    // interval scan waits for the scan interval
    apb(1'b1, ADDR_SCAN_IVL, 32'h2328);
    apb(1'b1, ADDR_SAMPLE_CNT, 32'h4);
    apb(1'b1, ADDR_CONTROL, acq_bit | scn_bit | ivl_bit);
    apb(1'b1, ADDR_ACQ_START, 32'h0);
    collect(4, 1'b1);
    cmp("gap", 32'h1, gap_ok(gaps[1], 32'ha28));
    cmp("gap", 32'h1, gap_ok(gaps[3], 32'h2328 - 2 * 32'ha28));
    give_verdict;
  end
endmodule
bind analog_input_acq_sequencer acq_seq_props acq_seq_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_convert_n(ext_convert_n), .ext_trigger_n(ext_trigger_n), .adc_result(adc_result),
  .adc_config(adc_config), .adc_busy(adc_busy),
  .result_fifo_not_empty(result_fifo_not_empty));
